// ### logic/imsp_top.sv
`timescale 1ns/1ps

module imsp_top #(
    parameter int ADDR_W = imsp_pkg::IMSP_ADDR_W,
    parameter logic [3:0] DEV_TYPE = imsp_pkg::IMSP_DEV_TYPE_DEF
) (
    // system clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // two-wire bus; scl also clocks the bit capture
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // straps
    input wire logic [2:0] device_select_pins_i,
    input wire logic wp_i,
    // status
    output logic active_o,
    output logic [ADDR_W-1:0] cur_addr_o
);
    import imsp_pkg::*;

    localparam int HI_W = ADDR_W - IMSP_DATA_W;

    // link domain: data bit taken on the rising clock edge
    logic link_bit;

    // synchronisers and edge history
    imsp_line_s line_s1;
    imsp_line_s line_s2;
    imsp_line_s line_s3;
    imsp_pins_s pins_s1;
    imsp_pins_s pins_s2;
    logic bit_s1;
    logic bit_s2;
    logic rise_d;

    // decoded bus events
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic cond_det;

    // protocol state
    imsp_state_e state;
    imsp_state_e ack_next;
    logic [3:0] bit_cnt;
    logic ack_ok;

    // datapath
    logic [IMSP_DATA_W-1:0] shreg;
    logic [IMSP_DATA_W-1:0] hi_byte;
    logic [IMSP_DATA_W-1:0] rd_byte;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] addr_inc;
    logic [IMSP_DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // combinational decisions
    logic rx_state;
    logic bit_step;
    logic byte_done;
    logic [IMSP_DATA_W-1:0] next_byte;
    logic dev_match;
    logic mem_we;
    logic rd_ack;
    logic next_ack_ok;
    imsp_state_e next_ack_target;

    // capture in the link domain; held stable for a whole clock high
    always_ff @(posedge scl_i) begin
        link_bit <= sda_i;
    end

    // two-stage synchronisers on the bus lines; the third stage is
    // only edge history, idle-high so reset makes no false edge
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            line_s1 <= IMSP_LINE_IDLE;
            line_s2 <= IMSP_LINE_IDLE;
            line_s3 <= IMSP_LINE_IDLE;
        end else begin
            line_s1 <= '{scl: scl_i, sda: sda_i};
            line_s2 <= line_s1;
            line_s3 <= line_s2;
        end
    end

    // strap pins are slow levels but still cross two flops
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pins_s1 <= IMSP_PINS_RST;
            pins_s2 <= IMSP_PINS_RST;
        end else begin
            pins_s1 <= '{sel: device_select_pins_i, wp: wp_i};
            pins_s2 <= pins_s1;
        end
    end

    // captured data bit; it holds for a whole scl high, so a plain
    // two-flop crossing is safe
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            bit_s1 <= 1'h1;
            bit_s2 <= 1'h1;
        end else begin
            bit_s1 <= link_bit;
            bit_s2 <= bit_s1;
        end
    end

    // edges and conditions look only at the second stage onward
    assign scl_rise = line_s2.scl & ~line_s3.scl;
    assign scl_fall = ~line_s2.scl & line_s3.scl;
    assign start_det = line_s2.scl & line_s3.scl &
                       line_s3.sda & ~line_s2.sda;
    assign stop_det = line_s2.scl & line_s3.scl &
                      ~line_s3.sda & line_s2.sda;
    assign cond_det = start_det | stop_det;

    // one cycle of slack so the crossed data bit has surely settled
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rise_d <= 1'h0;
        end else begin
            rise_d <= scl_rise;
        end
    end

    // byte assembly and decode
    assign rx_state = (state == IMSP_SLV_ADDR) || (state == IMSP_MEM_HI) ||
                      (state == IMSP_MEM_LO) || (state == IMSP_WR_DATA);
    assign bit_step = rise_d && !cond_det && rx_state &&
                      (bit_cnt != IMSP_CNT_DONE);
    assign next_byte = {shreg[IMSP_DATA_W-2:0], bit_s2};
    assign byte_done = bit_step && (bit_cnt == IMSP_CNT_LAST);
    assign dev_match =
        (next_byte[IMSP_TYPE_MSB:IMSP_TYPE_LSB] == DEV_TYPE) &&
        (next_byte[IMSP_SEL_MSB:IMSP_SEL_LSB] == pins_s2.sel);
    assign mem_we = byte_done && (state == IMSP_WR_DATA) &&
                    !pins_s2.wp;
    assign rd_ack = rise_d && !cond_det && (state == IMSP_RD_DATA) &&
                    (bit_cnt == IMSP_CNT_DONE) && !bit_s2;
    assign addr_inc = ADDR_W'(addr + 1'b1);

    // what the acknowledge slot will do once a byte is in
    always_comb begin
        next_ack_ok = 1'h0;
        next_ack_target = IMSP_IDLE;
        case (state)
            IMSP_SLV_ADDR: begin
                next_ack_ok = dev_match;
                if (next_byte[IMSP_RW_POS] == IMSP_RW_READ) begin
                    next_ack_target = IMSP_RD_DATA;
                end else begin
                    next_ack_target = IMSP_MEM_HI;
                end
            end
            IMSP_MEM_HI: begin
                next_ack_ok = 1'h1;
                next_ack_target = IMSP_MEM_LO;
            end
            IMSP_MEM_LO: begin
                next_ack_ok = 1'h1;
                next_ack_target = IMSP_WR_DATA;
            end
            IMSP_WR_DATA: begin
                next_ack_ok = !pins_s2.wp;
                next_ack_target = IMSP_WR_DATA;
            end
            default: begin
                next_ack_ok = 1'h0;
                next_ack_target = IMSP_IDLE;
            end
        endcase
    end

    // protocol sequencer; bus conditions override everything
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state <= IMSP_IDLE;
            ack_next <= IMSP_IDLE;
            bit_cnt <= IMSP_CNT_ZERO;
            ack_ok <= 1'h0;
        end else if (start_det) begin
            state <= IMSP_SLV_ADDR;
            bit_cnt <= IMSP_CNT_ZERO;
            ack_ok <= 1'h0;
        end else if (stop_det) begin
            state <= IMSP_IDLE;
            bit_cnt <= IMSP_CNT_ZERO;
            ack_ok <= 1'h0;
        end else begin
            case (state)
                IMSP_SLV_ADDR, IMSP_MEM_HI, IMSP_MEM_LO,
                IMSP_WR_DATA: begin
                    if (bit_step) begin
                        bit_cnt <= 4'(bit_cnt + 1'b1);
                    end
                    if (byte_done) begin
                        ack_ok <= next_ack_ok;
                        ack_next <= next_ack_target;
                    end
                    if (scl_fall && bit_cnt == IMSP_CNT_DONE) begin
                        // a refused byte drops out so we can be addressed
                        if (ack_ok) begin
                            state <= IMSP_ACK;
                        end else begin
                            state <= IMSP_IDLE;
                        end
                    end
                end
                IMSP_ACK: begin
                    if (scl_fall) begin
                        state <= ack_next;
                        bit_cnt <= IMSP_CNT_ZERO;
                    end
                end
                IMSP_RD_DATA: begin
                    if (rise_d) begin
                        if (bit_cnt != IMSP_CNT_DONE) begin
                            bit_cnt <= 4'(bit_cnt + 1'b1);
                        end else if (!bit_s2) begin
                            bit_cnt <= IMSP_CNT_ZERO;
                        end else begin
                            state <= IMSP_IDLE;
                        end
                    end
                end
                default: begin
                    state <= IMSP_IDLE;
                    bit_cnt <= IMSP_CNT_ZERO;
                end
            endcase
        end
    end

    // shift register: one bit per rising scl while receiving
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            shreg <= IMSP_BYTE_RST;
        end else if (bit_step) begin
            shreg <= next_byte;
        end
    end

    // high address byte waits here until the low byte completes it
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            hi_byte <= IMSP_BYTE_RST;
        end else if (byte_done && state == IMSP_MEM_HI) begin
            hi_byte <= next_byte;
        end
    end

    // address latch: survives start and stop, only reset clears it
    // a read bumps it at the eighth bit even if the master then stops
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            addr <= '0;
        end else if (byte_done && state == IMSP_MEM_LO) begin
            addr <= {hi_byte[HI_W-1:0], next_byte};
        end else if (mem_we) begin
            addr <= addr_inc;
        end else if (rise_d && !cond_det && state == IMSP_RD_DATA &&
                     bit_cnt == IMSP_CNT_LAST) begin
            addr <= addr_inc;
        end
    end

    // array write lands on the eighth bit, well before the acknowledge
    always_ff @(posedge mclk_i) begin
        if (mem_we) begin
            mem[addr] <= next_byte;
        end
    end

    // outgoing byte: fetched at the read address and on every master ack
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rd_byte <= IMSP_BYTE_RST;
        end else if (byte_done && state == IMSP_SLV_ADDR) begin
            rd_byte <= mem[addr];
        end else if (rd_ack) begin
            rd_byte <= mem[addr];
        end
    end

    // open-drain driver, changes only after a falling clock edge
    // and lets go at once on any start or stop
    always_ff @(posedge mclk_i) begin
        if (srst_i || cond_det) begin
            sda_oe_n_o <= 1'h1;
        end else if (scl_fall) begin
            case (state)
                IMSP_SLV_ADDR, IMSP_MEM_HI, IMSP_MEM_LO,
                IMSP_WR_DATA: begin
                    sda_oe_n_o <= !(bit_cnt == IMSP_CNT_DONE &&
                                    ack_ok);
                end
                IMSP_ACK: begin
                    if (ack_next == IMSP_RD_DATA) begin
                        sda_oe_n_o <= rd_byte[IMSP_DATA_W-1];
                    end else begin
                        sda_oe_n_o <= 1'h1;
                    end
                end
                IMSP_RD_DATA: begin
                    if (bit_cnt != IMSP_CNT_DONE) begin
                        sda_oe_n_o <= rd_byte[~bit_cnt[2:0]];
                    end else begin
                        sda_oe_n_o <= 1'h1;
                    end
                end
                default: begin
                    sda_oe_n_o <= 1'h1;
                end
            endcase
        end
    end

    // data pin only ever pulls low; the enable does the signalling
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sda_o <= 1'h0;
        end else begin
            sda_o <= 1'h0;
        end
    end

    // busy flag, one clock behind the sequencer
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            active_o <= 1'h0;
        end else begin
            active_o <= (state != IMSP_IDLE);
        end
    end

    // latch copy for observation, one clock behind the latch
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cur_addr_o <= '0;
        end else begin
            cur_addr_o <= addr;
        end
    end

endmodule

// ### logic/imsp_pkg.sv
package imsp_pkg;

    // memory geometry
    localparam int IMSP_ADDR_W = 15;
    localparam int IMSP_DATA_W = 8;

    // slave address byte layout
    localparam int IMSP_TYPE_MSB = 7;
    localparam int IMSP_TYPE_LSB = 4;
    localparam int IMSP_SEL_MSB = 3;
    localparam int IMSP_SEL_LSB = 1;
    localparam int IMSP_RW_POS = 0;
    localparam logic IMSP_RW_READ = 1'h1;

    // device type code; value is arbitrary, override per system
    localparam logic [3:0] IMSP_DEV_TYPE_DEF = 4'h6;

    // bit counter figures: last data bit index and byte complete
    localparam logic [3:0] IMSP_CNT_ZERO = 4'h0;
    localparam logic [3:0] IMSP_CNT_LAST = 4'h7;
    localparam logic [3:0] IMSP_CNT_DONE = 4'h8;

    // reset values
    localparam logic [7:0] IMSP_BYTE_RST = 8'h00;

    // protocol states
    typedef enum {
        IMSP_IDLE,
        IMSP_SLV_ADDR,
        IMSP_MEM_HI,
        IMSP_MEM_LO,
        IMSP_WR_DATA,
        IMSP_ACK,
        IMSP_RD_DATA
    } imsp_state_e;

    // the two bus lines as seen through the synchroniser
    typedef struct packed {
        logic scl;
        logic sda;
    } imsp_line_s;

    // static strap pins
    typedef struct packed {
        logic [2:0] sel;
        logic wp;
    } imsp_pins_s;

    localparam imsp_line_s IMSP_LINE_IDLE = '{scl: 1'h1, sda: 1'h1};
    localparam imsp_pins_s IMSP_PINS_RST = '{sel: 3'h0, wp: 1'h0};

endpackage

// ### tb/imsp_chk_asserts.sv
`timescale 1ns/1ps
module imsp_chk #(
    parameter int ADDR_W = 15
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // bus, straps and status
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic [2:0] device_select_pins_i,
    input wire logic wp_i,
    input wire logic active_o,
    input wire logic [ADDR_W-1:0] cur_addr_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);
    // open drain: the pin may only pull low
    chk_drive_low: assert property (sda_o == 1'b0)
        else $error("sda_o high");
    chk_reset_state: assert property ($fell(srst_i) |-> sda_oe_n_o
        && !active_o && cur_addr_o == '0) else $error("reset state");
    // two high scl samples keep data bits out of the conditions
    chk_stop_idle: assert property (
        scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:5] !active_o)
        else $error("stop ignored");
    chk_start_seen: assert property (
        scl_i && $past(scl_i) && $fell(sda_i)
        |-> ##[1:5] (sda_oe_n_o && active_o)) else $error("start ignored");
    // a pull starts three clocks after scl falls, never under high scl
    chk_pull_on_low: assert property (
        $fell(sda_oe_n_o) |-> !scl_i && !$past(scl_i, 2))
        else $error("pull while scl high");
    chk_idle_quiet: assert property (
        !active_o && !$past(active_o) |-> sda_oe_n_o)
        else $error("idle but pulling");
    chk_addr_idle: assert property (
        !active_o && !$past(active_o) |-> $stable(cur_addr_o))
        else $error("latch moved while idle");
    chk_wake_start: assert property (
        $rose(active_o) |-> scl_i && !sda_i) else $error("woke, no start");
endmodule

// ### tb/imsp_mst.sv
`timescale 1ns/1ps
module imsp_mst (
    // system clock paces every bus phase
    input wire logic mclk_i,
    // wire level in; own drive out, 1 releases to the pull-up
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // bus starts idle with both lines released
    initial ph(1'b1, 1'b1);
    // six clocks a phase, above the five the engine needs
    task automatic ph(input logic c, input logic d);
        scl_o = c;
        sda_o = d;
        repeat (6) @(negedge mclk_i);
    endtask
    // data moves only under low scl; sampled late in the high phase
    task automatic bitx(input logic b, output logic r);
        ph(1'b0, b);
        ph(1'b1, b);
        r = sda_i;
        ph(1'b0, b);
    endtask
    // works from idle or a low clock, so it also repeats a start
    task automatic start();
        ph(scl_o, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        ph(1'b0, 1'b0);
    endtask
    // master owns sda here, so it can raise it under high scl
    task automatic stop();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
    endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import imsp_pkg::*;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic wp_i = 1'b0;
    logic [2:0] sel = 3'h0;
    logic scl, msda, sda_o, sda_oe_n_o, active_o;
    logic [14:0] cur_addr_o, a;
    logic [8:0] q;
    logic [31:0] seed = 32'h5A16E461;
    logic [7:0] mem [0:32767];
    int miscompares = 0;
    int tests_run = 0;
    // wired-and with the pull-up: a released line reads high
    wire sda = msda & (sda_oe_n_o | sda_o);
    imsp_top i_imsp_top (
        .mclk_i(mclk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .device_select_pins_i(sel), .wp_i(wp_i),
        .active_o(active_o), .cur_addr_o(cur_addr_o));
    imsp_mst i_imsp_mst (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl),
        .sda_o(msda));
    // system clock
    initial forever #50 mclk_i = ~mclk_i;
    // bench random stream
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // next address as the latch should hold it, wrapping at the top
    function automatic logic [14:0] nxt(input logic [14:0] x);
        return (x == 15'h7FFF) ? 15'h0000 : x + 15'h0001;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t ns: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (miscompares == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // start, write slave byte, then both address bytes
    task automatic setaddr(input logic [14:0] ad);
        a = ad;
        i_imsp_mst.start();
        i_imsp_mst.xfer({IMSP_DEV_TYPE_DEF, sel, 2'h1}, q);
        check(q[0], 1'b0);
        i_imsp_mst.xfer({1'b1, ad[14:8], 1'b1}, q);
        check(q[0], 1'b0);
        i_imsp_mst.xfer({ad[7:0], 1'b1}, q);
        check(q[0], 1'b0);
    endtask
    // random data bytes; a refused byte leaves model and latch alone
    task automatic wd(input int n, input logic nak);
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            i_imsp_mst.xfer({seed[7:0], 1'b1}, q);
            check(q[0], nak);
            if (!nak) begin
                mem[a] = seed[7:0];
                a = nxt(a);
            end
        end
    endtask
    // repeated start, read n bytes, master refuses the last one
    task automatic rd(input int n);
        i_imsp_mst.start();
        i_imsp_mst.xfer({IMSP_DEV_TYPE_DEF, sel, 2'h3}, q);
        check(q[0], 1'b0);
        for (int i = 0; i < n; i++) begin
            i_imsp_mst.xfer({8'hFF, 1'(i == n - 1)}, q);
            check(q[8:1], mem[a]);
            a = nxt(a);
        end
        check(active_o, 1'b0);
        i_imsp_mst.stop();
    endtask
    // hang guard well above the longest sequence
    initial begin
        repeat (50000) @(posedge mclk_i);
        miscompares++;
        conclude();
    end
    // reset, random device select pins, then the sequences
    initial begin
        repeat (20) @(negedge mclk_i);
        srst_i = 1'b0;
        seed = lfsr(seed);
        sel = seed[2:0];
        repeat (5) @(negedge mclk_i);
        setaddr(15'h7FFE);
        wd(4, 1'b0);
        i_imsp_mst.stop();
        check(cur_addr_o, a);
        setaddr(15'h7FFE);
        rd(4);
        for (int i = 1; i < 8; i++) begin
            i_imsp_mst.start();
            i_imsp_mst.xfer({IMSP_DEV_TYPE_DEF, sel ^ 3'(i), 2'h1}, q);
            check(q[0], 1'b1);
        end
        i_imsp_mst.start();
        i_imsp_mst.xfer({~IMSP_DEV_TYPE_DEF, sel, 2'h3}, q);
        check(q[0], 1'b1);
        setaddr(15'h0005);
        wd(1, 1'b0);
        wp_i = 1'b1;
        setaddr(15'h0005);
        wd(1, 1'b1);
        wp_i = 1'b0;
        i_imsp_mst.stop();
        check(cur_addr_o, 15'h0005);
        setaddr(15'h0005);
        repeat (4) i_imsp_mst.bitx(1'b0, q[0]);
        i_imsp_mst.stop();
        check(active_o, 1'b0);
        check(cur_addr_o, 15'h0005);
        setaddr(15'h0005);
        rd(1);
        conclude();
    end
endmodule

bind imsp_top imsp_chk #(.ADDR_W(ADDR_W)) i_imsp_chk (
    .mclk_i(mclk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wp_i(wp_i),
    .device_select_pins_i(device_select_pins_i), .active_o(active_o),
    .cur_addr_o(cur_addr_o));
